// ===== design/aux_and_ext_regulator_control.v
// Enable and stage control for the auxiliary and external-transistor regulators
`timescale 1ns/10ps
`default_nettype none
`include "aux_ext_map.vh"

module aux_and_ext_regulator_control (
    // Clock and power-up reset
    input  wire                  ref_clk,
    input  wire                  sys_rst,
    // Soft reset from the mode logic, keeps the configuration lock
    input  wire                  soft_rst,
    // One-hot device mode from the mode state machine
    input  wire [`MODE_W-1:0]    sbc_mode,
    // Main regulator running or ramping
    input  wire                  main_regulator_on,
    // Mode control register write
    input  wire                  mode_ctrl_wr,
    input  wire                  aux_enable_bit,
    input  wire                  standalone_enable_bit,
    // Hardware control register write
    input  wire                  hardware_control_reg_wr,
    input  wire                  load_share_select_bit,
    input  wire                  ext_voltage_select_bit,
    input  wire                  keep_on_at_supply_low_bit,
    input  wire                  load_share_stop_keep_bit,
    // Analog comparator flags, asynchronous
    input  wire                  aux_peak_rise_threshold,
    input  wire                  aux_peak_fall_threshold,
    input  wire                  ext_base_rise_threshold,
    input  wire                  ext_base_fall_threshold,
    input  wire                  battery_undervoltage,
    // Auxiliary regulator controls
    output wire                  aux_lp_stage_on,
    output wire                  aux_hp_stage_on,
    output wire                  aux_enable_state,
    // External regulator controls
    output wire                  ext_lp_stage_on,
    output wire                  ext_hp_stage_on,
    output wire                  ext_vsel_1v8,
    // Configuration status
    output wire                  cfg_standalone,
    output wire                  cfg_load_share,
    output wire                  cfg_locked,
    output wire                  spi_fail_pulse
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    wire [`FLAG_W-1:0] flag_sync;
    wire               m_init;
    wire               m_norm;
    wire               m_stop;
    wire               m_sleep;
    wire               m_rst;
    wire               m_fs;
    wire               restart_entry;
    wire               locked;
    wire               supply_cut;

    reg  [`MODE_W-1:0] mode_prev_reg;
    reg                cfg_sa_reg;
    reg                cfg_ls_reg;
    reg                aux_en_reg;
    reg                aux_en_next;
    reg                ext_sw_reg;
    reg                ext_sw_next;
    reg                vsel_reg;
    reg                keep_on_reg;
    reg                stop_keep_reg;
    reg                aux_hp_dyn_reg;
    reg                aux_hp_dyn_next;
    reg                ext_hp_dyn_reg;
    reg                ext_hp_dyn_next;
    reg                ext_want_reg;
    reg                ext_want_next;
    reg                set_sa;
    reg                set_ls;
    reg                fail_next;
    reg                fail_reg;
    reg                aux_lp_reg;
    reg                aux_lp_next;
    reg                aux_hp_reg;
    reg                aux_hp_next;
    reg                ext_lp_reg;
    reg                ext_lp_next;
    reg                ext_hp_reg;
    reg                ext_hp_next;
    reg                ext_vsel_reg;

    // ****************************************************************
    // Pin flag synchronisation
    // ****************************************************************
    flag_sync3 u_sync (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .raw_in    ({battery_undervoltage,
                     ext_base_fall_threshold,
                     ext_base_rise_threshold,
                     aux_peak_fall_threshold,
                     aux_peak_rise_threshold}),
        .clean_out (flag_sync)
    );

    // Mode decode and derived conditions
    assign m_init        = sbc_mode[`MODE_INIT];
    assign m_norm        = sbc_mode[`MODE_NORMAL];
    assign m_stop        = sbc_mode[`MODE_STOP];
    assign m_sleep       = sbc_mode[`MODE_SLEEP];
    assign m_rst         = sbc_mode[`MODE_RESTART];
    assign m_fs          = sbc_mode[`MODE_FAILSAFE];
    assign restart_entry = m_rst & ~mode_prev_reg[`MODE_RESTART];
    assign locked        = cfg_sa_reg | cfg_ls_reg;
    assign supply_cut    = flag_sync[`FLAG_BAT_UV] & ~keep_on_reg;

    // ****************************************************************
    // Configuration selection, lock and error flag
    // ****************************************************************
    // Load share wins if both requests land in the same cycle
    always @* begin
        set_ls    = 1'b0;
        set_sa    = 1'b0;
        fail_next = 1'b0;
        if (!locked) begin
            if (hardware_control_reg_wr && load_share_select_bit) begin
                set_ls = 1'b1;
            end else if (mode_ctrl_wr && m_norm && standalone_enable_bit) begin
                set_sa = 1'b1;
            end
        end else if (cfg_ls_reg) begin
            // Clearing load share or asking for stand-alone is an error
            if ((hardware_control_reg_wr && !load_share_select_bit) ||
                (mode_ctrl_wr && standalone_enable_bit)) begin
                fail_next = 1'b1;
            end
        end
        // Stand-alone locked: a load-share request is dropped quietly
    end

    // Lock only clears on power-up reset, not on soft reset
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg_sa_reg <= `CTRL_RST_VAL;
            cfg_ls_reg <= `CTRL_RST_VAL;
        end else begin
            if (set_sa) begin
                cfg_sa_reg <= 1'b1;
            end
            if (set_ls) begin
                cfg_ls_reg <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Host control bits
    // ****************************************************************
    // Aux enable is written in Normal and latched off on Restart entry
    always @* begin
        aux_en_next = aux_en_reg;
        ext_sw_next = ext_sw_reg;
        if (restart_entry) begin
            aux_en_next = 1'b0;
        end else if (mode_ctrl_wr && m_norm) begin
            aux_en_next = aux_enable_bit;
        end
        if (mode_ctrl_wr && m_norm && (cfg_sa_reg || set_sa)) begin
            ext_sw_next = standalone_enable_bit;
        end
    end

    // Soft reset clears host bits but leaves the lock alone
    always @(posedge ref_clk) begin
        if (sys_rst || soft_rst) begin
            aux_en_reg    <= `CTRL_RST_VAL;
            ext_sw_reg    <= `CTRL_RST_VAL;
            vsel_reg      <= `CTRL_RST_VAL;
            keep_on_reg   <= `CTRL_RST_VAL;
            stop_keep_reg <= `CTRL_RST_VAL;
            mode_prev_reg <= `MODE_RST_VAL;
            fail_reg      <= 1'b0;
        end else begin
            aux_en_reg    <= aux_en_next;
            ext_sw_reg    <= ext_sw_next;
            mode_prev_reg <= sbc_mode;
            fail_reg      <= fail_next;
            if (hardware_control_reg_wr) begin
                vsel_reg      <= ext_voltage_select_bit;
                keep_on_reg   <= keep_on_at_supply_low_bit;
                stop_keep_reg <= load_share_stop_keep_bit;
            end
        end
    end

    // ****************************************************************
    // Dynamic high-power stage in low-power modes
    // ****************************************************************
    // Rise sets (aux only in Stop, Sleep clears aux), fall clears; rise wins so a load step is never missed
    always @* begin
        aux_hp_dyn_next = aux_hp_dyn_reg;
        ext_hp_dyn_next = ext_hp_dyn_reg;
        if (!(m_stop || m_sleep)) begin
            aux_hp_dyn_next = 1'b0;
            ext_hp_dyn_next = 1'b0;
        end else begin
            if (flag_sync[`FLAG_AUX_RISE]) begin
                aux_hp_dyn_next = m_stop;
            end else if (flag_sync[`FLAG_AUX_FALL]) begin
                aux_hp_dyn_next = 1'b0;
            end
            if (flag_sync[`FLAG_EXT_RISE]) begin
                ext_hp_dyn_next = 1'b1;
            end else if (flag_sync[`FLAG_EXT_FALL]) begin
                ext_hp_dyn_next = 1'b0;
            end
        end
    end

    // ****************************************************************
    // External regulator wanted state per mode
    // ****************************************************************
    // Stand-alone holds the last state outside Normal/Init/Fail-Safe
    always @* begin
        ext_want_next = ext_want_reg;
        if (cfg_ls_reg) begin
            if (m_norm) begin
                ext_want_next = 1'b1;
            end else if (m_rst) begin
                ext_want_next = main_regulator_on;
            end else if (m_stop) begin
                ext_want_next = stop_keep_reg;
            end else begin
                ext_want_next = 1'b0;
            end
        end else if (cfg_sa_reg) begin
            if (m_init || m_fs) begin
                ext_want_next = 1'b0;
            end else if (m_norm) begin
                ext_want_next = ext_sw_reg;
            end
        end else begin
            ext_want_next = 1'b0;
        end
    end

    // ****************************************************************
    // Stage outputs
    // ****************************************************************
    // Aux stays off outside Normal, Stop and Sleep
    always @* begin
        aux_lp_next = 1'b0;
        aux_hp_next = 1'b0;
        ext_lp_next = 1'b0;
        ext_hp_next = 1'b0;
        if (aux_en_reg && (m_norm || m_stop || m_sleep)) begin
            aux_lp_next = 1'b1;
            aux_hp_next = m_norm | aux_hp_dyn_reg;
        end
        // Undervoltage cut is a level, so recovery re-enables by itself
        if (ext_want_reg && !supply_cut) begin
            if (m_stop || m_sleep) begin
                ext_lp_next = 1'b1;
                ext_hp_next = ext_hp_dyn_reg;
            end else begin
                ext_hp_next = 1'b1;
            end
        end
    end

    // Registered outputs; dynamic state cleared on soft reset too
    always @(posedge ref_clk) begin
        if (sys_rst || soft_rst) begin
            aux_hp_dyn_reg <= 1'b0;
            ext_hp_dyn_reg <= 1'b0;
            ext_want_reg   <= 1'b0;
            aux_lp_reg     <= 1'b0;
            aux_hp_reg     <= 1'b0;
            ext_lp_reg     <= 1'b0;
            ext_hp_reg     <= 1'b0;
            ext_vsel_reg   <= 1'b0;
        end else begin
            aux_hp_dyn_reg <= aux_hp_dyn_next;
            ext_hp_dyn_reg <= ext_hp_dyn_next;
            ext_want_reg   <= ext_want_next;
            aux_lp_reg     <= aux_lp_next;
            aux_hp_reg     <= aux_hp_next;
            ext_lp_reg     <= ext_lp_next;
            ext_hp_reg     <= ext_hp_next;
            ext_vsel_reg   <= cfg_sa_reg & vsel_reg;
        end
    end

    // ****************************************************************
    // Output wiring
    // ****************************************************************
    assign aux_lp_stage_on  = aux_lp_reg;
    assign aux_hp_stage_on  = aux_hp_reg;
    assign aux_enable_state = aux_en_reg;
    assign ext_lp_stage_on  = ext_lp_reg;
    assign ext_hp_stage_on  = ext_hp_reg;
    assign ext_vsel_1v8     = ext_vsel_reg;
    assign cfg_standalone   = cfg_sa_reg;
    assign cfg_load_share   = cfg_ls_reg;
    assign cfg_locked       = locked;
    assign spi_fail_pulse   = fail_reg;

endmodule

`default_nettype wire

// ===== design/flag_sync3.v
// Three-stage synchroniser with agreement filter for pin flags
`timescale 1ns/10ps
`default_nettype none
`include "aux_ext_map.vh"

module flag_sync3 (
    // Clock and reset
    input  wire                  ref_clk,
    input  wire                  sys_rst,
    // Raw pin levels
    input  wire [`FLAG_W-1:0]    raw_in,
    // Filtered levels
    output wire [`FLAG_W-1:0]    clean_out
);

    genvar i;

    // ****************************************************************
    // One chain per flag
    // ****************************************************************
    generate
        for (i = 0; i < `FLAG_W; i = i + 1) begin : g_bit
            reg s1_reg;
            reg s2_reg;
            reg s3_reg;
            reg out_reg;
            // First stage feeds only the second, so no logic sees metastability
            always @(posedge ref_clk) begin
                if (sys_rst) begin
                    s1_reg  <= 1'b0;
                    s2_reg  <= 1'b0;
                    s3_reg  <= 1'b0;
                    out_reg <= 1'b0;
                end else begin
                    s1_reg <= raw_in[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        out_reg <= s3_reg;
                    end
                end
            end
            assign clean_out[i] = out_reg;
        end
    endgenerate

endmodule

`default_nettype wire

// ===== shared/aux_ext_map.vh
// Constants for the auxiliary and external-transistor regulator control
//
// Notes on behaviour
// - Normal mode: aux output follows its enable bit.
// - Stop: aux low-power stage, high-power on rising flag.
// - Stop: aux high-power stage off on falling flag.
// - Normal: both aux stages on while enabled.
// - Stand-alone bit written in Normal selects stand-alone.
// - Load-share bit selects load-sharing configuration.
// - First configuration set locks the selection.
// - Lock survives soft reset, cleared at power-up.
// - Stand-alone voltage bit: 0 3.3V, 1 1.8V.
// - Stop: ext low-power stage, high-power on rising flag.
// - Ext high-power stage off on falling flag.
// - Normal: ext uses high-power stage only.
// - Supply low turns ext off unless keep-on set.
// - Load share plus stop-keep keeps ext on in Stop.
// - Stand-alone: off Init/Fail-Safe, host in Normal, else hold.
// - Load share follows main regulator per mode.
// - Restart entry latches aux off until SPI re-enable.
// - Aux only in Normal, Stop, Sleep; never Fail-Safe.
// - Stand-alone: on/off allowed, change attempt silently ignored.
// - Load share: change attempt flags SPI error.
`ifndef AUX_EXT_MAP_VH
`define AUX_EXT_MAP_VH

// ****************************************************************
// Device mode one-hot bit positions
// ****************************************************************
`define MODE_W          6
`define MODE_INIT       0
`define MODE_NORMAL     1
`define MODE_STOP       2
`define MODE_SLEEP      3
`define MODE_RESTART    4
`define MODE_FAILSAFE   5

// ****************************************************************
// Synchronised flag positions
// ****************************************************************
`define FLAG_W          5
`define FLAG_AUX_RISE   0
`define FLAG_AUX_FALL   1
`define FLAG_EXT_RISE   2
`define FLAG_EXT_FALL   3
`define FLAG_BAT_UV     4
`define FLAG_RST_VAL    5'h0_0

// ****************************************************************
// Reset values of control bits
// ****************************************************************
`define CTRL_RST_VAL    1'b0
`define MODE_RST_VAL    6'h0_1

`endif

// ===== tb/host_model.sv
// Host model issuing control register writes
`timescale 1ns/10ps
`default_nettype none

module host_model (
    // Clock
    input wire logic ref_clk,
    // Mode control write
    output var logic mode_ctrl_wr,
    output var logic aux_enable_bit,
    output var logic standalone_enable_bit,
    // Hardware control write
    output var logic hardware_control_reg_wr,
    output var logic load_share_select_bit,
    output var logic ext_voltage_select_bit,
    output var logic keep_on_at_supply_low_bit,
    output var logic load_share_stop_keep_bit
);
    // Idle with no strobe at time zero
    initial begin
        {mode_ctrl_wr, aux_enable_bit, standalone_enable_bit} = 3'h0;
        {hardware_control_reg_wr, load_share_select_bit, ext_voltage_select_bit} = 3'h0;
        {keep_on_at_supply_low_bit, load_share_stop_keep_bit} = 2'h0;
    end

    // One-cycle write; data turns to garbage once the strobe drops
    // Callers write in Normal except one aux write in Stop, and configure at power-up
    task wr_mode(input logic a, input logic s);
        @(negedge ref_clk);
        {mode_ctrl_wr, aux_enable_bit, standalone_enable_bit} = {1'b1, a, s};
        @(negedge ref_clk);
        {mode_ctrl_wr, aux_enable_bit, standalone_enable_bit} = {1'b0, ~a, ~s};
    endtask

    task wr_hw(input logic l, input logic v, input logic k, input logic p);
        @(negedge ref_clk);
        hardware_control_reg_wr = 1'b1;
        {load_share_select_bit, ext_voltage_select_bit, keep_on_at_supply_low_bit, load_share_stop_keep_bit} = {l, v, k, p};
        @(negedge ref_clk);
        hardware_control_reg_wr = 1'b0;
        {load_share_select_bit, ext_voltage_select_bit, keep_on_at_supply_low_bit, load_share_stop_keep_bit} = ~{l, v, k, p};
    endtask
endmodule
`default_nettype wire

// ===== tb/reg_ctrl_checker_asserts.sv
// Concurrent checks on the regulator control ports
`timescale 1ns/10ps
`default_nettype none
`include "aux_ext_map.vh"

module reg_ctrl_checker (
    // Clock and resets
    input wire logic               ref_clk,
    input wire logic               sys_rst,
    input wire logic               soft_rst,
    // Mode and register writes
    input wire logic [`MODE_W-1:0] sbc_mode,
    input wire logic               mode_ctrl_wr,
    input wire logic               aux_enable_bit,
    input wire logic               standalone_enable_bit,
    input wire logic               hardware_control_reg_wr,
    input wire logic               load_share_select_bit,
    // Watched outputs
    input wire logic               aux_lp_stage_on,
    input wire logic               aux_hp_stage_on,
    input wire logic               aux_enable_state,
    input wire logic               ext_lp_stage_on,
    input wire logic               ext_vsel_1v8,
    input wire logic               cfg_standalone,
    input wire logic               cfg_load_share,
    input wire logic               cfg_locked,
    input wire logic               spi_fail_pulse
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Three settled cycles cover the one-register stage path
    sequence aux_normal_on;
        (sbc_mode[`MODE_NORMAL] && aux_enable_state && !soft_rst)[*3];
    endsequence
    sequence ls_change_try;
        cfg_load_share && !soft_rst && ((hardware_control_reg_wr && !load_share_select_bit)
            || (mode_ctrl_wr && standalone_enable_bit && sbc_mode[`MODE_NORMAL]));
    endsequence

    aux_write_a: assert property (sbc_mode[`MODE_NORMAL] && mode_ctrl_wr && !soft_rst
        |=> aux_enable_state == $past(aux_enable_bit)) else $error("aux enable not stored");
    aux_both_a: assert property (aux_normal_on |=> aux_lp_stage_on && aux_hp_stage_on)
        else $error("aux stages not both on");
    aux_failsafe_a: assert property (sbc_mode[`MODE_FAILSAFE][*3]
        |=> !aux_lp_stage_on && !aux_hp_stage_on) else $error("aux on in fail-safe");
    restart_off_a: assert property ($rose(sbc_mode[`MODE_RESTART]) ##1 1'b1
        |=> !aux_enable_state) else $error("aux not latched off");
    ext_hponly_a: assert property (sbc_mode[`MODE_NORMAL][*3] |=> !ext_lp_stage_on)
        else $error("ext low-power stage on in normal");
    lock_keep_a: assert property (cfg_locked |=> $stable({cfg_standalone, cfg_load_share}))
        else $error("locked configuration changed");
    ls_fail_a: assert property (ls_change_try |=> spi_fail_pulse)
        else $error("no error pulse on change");
    sa_quiet_a: assert property (cfg_standalone && (hardware_control_reg_wr || mode_ctrl_wr) |=> !spi_fail_pulse)
        else $error("error pulse in stand-alone");
    vsel_ls_a: assert property (cfg_load_share[*3] |=> !ext_vsel_1v8)
        else $error("voltage select not ignored");
endmodule

bind aux_and_ext_regulator_control reg_ctrl_checker u_chk (.ref_clk, .sys_rst, .soft_rst, .sbc_mode,
    .mode_ctrl_wr, .aux_enable_bit, .standalone_enable_bit, .hardware_control_reg_wr, .load_share_select_bit,
    .aux_lp_stage_on, .aux_hp_stage_on, .aux_enable_state, .ext_lp_stage_on, .ext_vsel_1v8,
    .cfg_standalone, .cfg_load_share, .cfg_locked, .spi_fail_pulse);
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the regulator control block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    localparam [5:0] INIT = 6'h01, NORM = 6'h02, STOP = 6'h04, SLP = 6'h08, RSTM = 6'h10, FS = 6'h20;
    logic ref_clk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, main_regulator_on = 1'b0;
    logic [5:0] sbc_mode = INIT;
    logic aux_peak_rise_threshold = 1'b0, aux_peak_fall_threshold = 1'b0, ext_base_rise_threshold = 1'b0;
    logic ext_base_fall_threshold = 1'b0, battery_undervoltage = 1'b0;
    wire logic mode_ctrl_wr, aux_enable_bit, standalone_enable_bit, hardware_control_reg_wr, load_share_select_bit;
    wire logic ext_voltage_select_bit, keep_on_at_supply_low_bit, load_share_stop_keep_bit;
    wire logic aux_lp_stage_on, aux_hp_stage_on, aux_enable_state, ext_lp_stage_on, ext_hp_stage_on;
    wire logic ext_vsel_1v8, cfg_standalone, cfg_load_share, cfg_locked, spi_fail_pulse;
    int errors = 0, compares = 0, cycles = 0;

    always #20 ref_clk = ~ref_clk;

    host_model u_host (.ref_clk, .mode_ctrl_wr, .aux_enable_bit, .standalone_enable_bit, .hardware_control_reg_wr,
        .load_share_select_bit, .ext_voltage_select_bit, .keep_on_at_supply_low_bit, .load_share_stop_keep_bit);
    aux_and_ext_regulator_control u_dut (.ref_clk, .sys_rst, .soft_rst, .sbc_mode, .main_regulator_on,
        .mode_ctrl_wr, .aux_enable_bit, .standalone_enable_bit, .hardware_control_reg_wr, .load_share_select_bit,
        .ext_voltage_select_bit, .keep_on_at_supply_low_bit, .load_share_stop_keep_bit,
        .aux_peak_rise_threshold, .aux_peak_fall_threshold, .ext_base_rise_threshold,
        .ext_base_fall_threshold, .battery_undervoltage, .aux_lp_stage_on, .aux_hp_stage_on,
        .aux_enable_state, .ext_lp_stage_on, .ext_hp_stage_on, .ext_vsel_1v8, .cfg_standalone,
        .cfg_load_share, .cfg_locked, .spi_fail_pulse);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task chk(input logic seen, input logic exp, input string what);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s saw %b", $time, what, seen);
        end
    endtask

    // Mode settles through two registers, so n is three wherever stage outputs are checked
    task go(input logic [5:0] m, input int n);
        @(negedge ref_clk);
        sbc_mode = m;
        repeat (n) @(negedge ref_clk);
    endtask

    // Flags cross a filtering synchroniser; ten cycles is past its worst case
    task flg(input logic [4:0] f);
        @(negedge ref_clk);
        {battery_undervoltage, ext_base_fall_threshold, ext_base_rise_threshold} = f[4:2];
        {aux_peak_fall_threshold, aux_peak_rise_threshold} = f[1:0];
        repeat (10) @(negedge ref_clk);
    endtask

    task reset_all;
        @(negedge ref_clk);
        sys_rst = 1'b1;
        repeat (5) @(negedge ref_clk);
        sys_rst = 1'b0;
        sbc_mode = INIT;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_aux;
        go(NORM, 3);
        u_host.wr_mode(1'b1, 1'b0);
        chk(aux_enable_state, 1'b1, "aux stored");
        repeat (2) @(negedge ref_clk);
        chk(aux_lp_stage_on & aux_hp_stage_on, 1'b1, "aux normal");
        u_host.wr_mode(1'b0, 1'b0);
        repeat (2) @(negedge ref_clk);
        chk(aux_lp_stage_on | aux_hp_stage_on, 1'b0, "aux off");
        u_host.wr_mode(1'b1, 1'b0);
        go(STOP, 3);
        flg(5'h02);
        chk(aux_lp_stage_on, 1'b1, "aux stop lp");
        chk(aux_hp_stage_on, 1'b0, "aux stop hp low");
        flg(5'h01);
        chk(aux_hp_stage_on, 1'b1, "aux hp rise");
        flg(5'h02);
        chk(aux_hp_stage_on, 1'b0, "aux hp fall");
        flg(5'h00);
        u_host.wr_mode(1'b0, 1'b0);
        chk(aux_enable_state, 1'b1, "aux write outside normal");
        go(FS, 3);
        chk(aux_lp_stage_on | aux_hp_stage_on, 1'b0, "aux fail-safe");
        go(RSTM, 2);
        chk(aux_enable_state, 1'b0, "aux restart");
        go(NORM, 3);
        chk(aux_lp_stage_on, 1'b0, "aux stays latched");
    endtask

    task t_sa;
        reset_all;
        go(NORM, 3);
        u_host.wr_hw(1'b0, 1'b1, 1'b0, 1'b0);
        u_host.wr_mode(1'b0, 1'b1);
        chk(cfg_standalone, 1'b1, "stand-alone set");
        repeat (2) @(negedge ref_clk);
        chk(ext_hp_stage_on, 1'b1, "ext on");
        chk(ext_lp_stage_on, 1'b0, "ext lp normal");
        chk(ext_vsel_1v8, 1'b1, "ext 1.8V");
        u_host.wr_hw(1'b1, 1'b0, 1'b0, 1'b0);
        chk(spi_fail_pulse, 1'b0, "silent ignore");
        chk(cfg_load_share, 1'b0, "config kept");
        repeat (2) @(negedge ref_clk);
        chk(ext_vsel_1v8, 1'b0, "ext 3.3V");
        flg(5'h10);
        chk(ext_hp_stage_on, 1'b0, "supply low cut");
        flg(5'h00);
        chk(ext_hp_stage_on, 1'b1, "supply recovered");
        go(STOP, 3);
        flg(5'h08);
        chk(ext_lp_stage_on, 1'b1, "ext stop lp");
        chk(ext_hp_stage_on, 1'b0, "ext hp fall");
        flg(5'h04);
        chk(ext_hp_stage_on, 1'b1, "ext hp rise");
        flg(5'h00);
        go(FS, 3);
        chk(ext_lp_stage_on | ext_hp_stage_on, 1'b0, "ext fail-safe");
        @(negedge ref_clk);
        soft_rst = 1'b1;
        @(negedge ref_clk);
        soft_rst = 1'b0;
        chk(cfg_standalone, 1'b1, "lock kept");
        chk(cfg_locked, 1'b1, "lock flag");
        go(NORM, 3);
        u_host.wr_mode(1'b0, 1'b1);
        u_host.wr_hw(1'b0, 1'b0, 1'b1, 1'b0);
        flg(5'h10);
        chk(ext_hp_stage_on, 1'b1, "keep-on");
        flg(5'h00);
        u_host.wr_mode(1'b0, 1'b0);
        repeat (2) @(negedge ref_clk);
        chk(ext_hp_stage_on, 1'b0, "host off");
    endtask

    task t_ls;
        reset_all;
        go(NORM, 3);
        u_host.wr_hw(1'b1, 1'b1, 1'b0, 1'b0);
        chk(cfg_load_share, 1'b1, "load share set");
        repeat (2) @(negedge ref_clk);
        chk(ext_hp_stage_on, 1'b1, "ls on");
        chk(ext_vsel_1v8, 1'b0, "vsel ignored");
        u_host.wr_hw(1'b0, 1'b0, 1'b0, 1'b0);
        chk(spi_fail_pulse, 1'b1, "hw change error");
        u_host.wr_mode(1'b0, 1'b1);
        chk(spi_fail_pulse, 1'b1, "mode change error");
        chk(cfg_standalone, 1'b0, "config unchanged");
        go(STOP, 3);
        chk(ext_lp_stage_on | ext_hp_stage_on, 1'b0, "ls stop off");
        go(NORM, 1);
        u_host.wr_hw(1'b1, 1'b0, 1'b0, 1'b1);
        go(STOP, 3);
        chk(ext_lp_stage_on, 1'b1, "ls stop kept");
        go(SLP, 3);
        chk(ext_lp_stage_on | ext_hp_stage_on, 1'b0, "ls sleep");
        go(RSTM, 3);
        chk(ext_lp_stage_on | ext_hp_stage_on, 1'b0, "ls restart off");
        main_regulator_on = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(ext_lp_stage_on | ext_hp_stage_on, 1'b1, "ls restart");
        go(FS, 3);
        chk(ext_lp_stage_on | ext_hp_stage_on, 1'b0, "ls fail-safe");
    endtask

    // ****************************************************************
    // Verdict, watchdog and main sequence
    // ****************************************************************
    task close_out;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // The whole run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            close_out;
        end
    end

    initial begin
        reset_all;
        t_aux;
        t_sa;
        t_ls;
        close_out;
    end
endmodule
`default_nettype wire
